// File: core/hcs_pkg.sv
// constants and types of the host command and state controller
// assumes one 100 MHz clock and a synchronous active-high reset
`default_nettype none
package hcs_pkg;
   localparam int ADDR_W = 24;
   localparam int DATA_W = 16;
   localparam int NUM_SRC = 16;
   localparam logic [7:0] HS_BUSY = 8'hFE;
   localparam logic [7:0] HS_DONE = 8'hFF;
   localparam logic [7:0] VEC_RESET = 8'h0F;
   localparam logic [7:0] SEV_STEP = 8'h01;
   // command codes; the top three bits give the group
   localparam logic [7:0] CMD_RESET = 8'h00;
   localparam logic [7:0] CMD_INIT = 8'h01;
   localparam logic [7:0] CMD_BUS16 = 8'h02;
   localparam logic [7:0] CMD_BUS8 = 8'h03;
   localparam logic [7:0] CMD_GO_IDLE = 8'h40;
   localparam logic [7:0] CMD_GO_ACTIVE = 8'h41;
   localparam int GRP_LSB = 5;
   localparam int NUM_GRP = 5;
   // interrupt queue entry: two halfwords, four bytes a slot
   localparam int SLOT_SHIFT = 2;
   localparam logic [23:0] HALF_OFS = 24'h000002;
   localparam logic [3:0] CTL_IDLE = 4'hF;
   localparam logic STYLE_A = 1'b0;
   typedef enum logic [2:0] {
      ST_OFF = 3'b001,
      ST_ON  = 3'b010,
      ST_ERR = 3'b100
   } hcs_op_t;
   typedef enum logic [2:0] {
      EQ_IDLE = 3'b001,
      EQ_W0   = 3'b010,
      EQ_W1   = 3'b100
   } hcs_eq_t;
   typedef enum logic [2:0] {
      BM_IDLE = 3'b001,
      BM_BEAT = 3'b010,
      BM_GAP  = 3'b100
   } hcs_bm_t;
endpackage
`default_nettype wire

// File: core/hcs_bm_if.sv
// request channel from the controller to its bus master engine
// assumes both ends share one clock
`default_nettype none
interface hcs_bm_if;
   logic        req;
   logic        bus8;
   logic        style;
   logic [23:0] addr;
   logic [15:0] wdata;
   logic        busy;
   logic        done;
   logic        fault;
   modport ctrl (output req, bus8, style, addr, wdata,
                 input busy, done, fault);
   modport mst (input req, bus8, style, addr, wdata,
                output busy, done, fault);
endinterface
`default_nettype wire

// File: core/hcs_bus_master.sv
// bus master write engine: one halfword per request
// assumes the slave answers with ack; abort inputs end the cycle
`default_nettype none
module hcs_bus_master
   import hcs_pkg::*;
(
   input  wire logic         clk,
   input  wire logic         srst,
   hcs_bm_if.mst             bm,
   input  wire logic         bus_ack,
   input  wire logic         bus_fault,
   input  wire logic         dev_sel,
   input  wire logic         int_ack,
   output logic [23:0]       bus_addr,
   output logic [15:0]       bus_dout,
   output logic              bus_doe,
   output logic [3:0]        bus_ctl,
   output logic              bus_own
);
   hcs_bm_t     st;
   hcs_bm_t     next_st;
   logic        sec;
   logic        bus8_q;
   logic        style_q;
   logic [23:0] adr_q;
   logic [15:0] w_q;

   wire        start = (st == BM_IDLE) && bm.req;
   wire        abort = bus_fault || dev_sel || int_ack;
   wire        last = !bus8_q || sec;
   wire        ack_last = (st == BM_BEAT) && bus_ack && !abort && last;
   // a wide bus never sees an odd address
   wire [23:0] src_adr = start ? {bm.addr[23:1], bm.addr[0] & bm.bus8}
                               : adr_q;
   wire [15:0] src_w = start ? bm.wdata : w_q;
   wire        src_8 = start ? bm.bus8 : bus8_q;
   wire        src_sty = start ? bm.style : style_q;
   wire        next_sec = start ? 1'b0 : (sec || (st == BM_GAP));
   wire [23:0] beat_adr = src_adr + {23'h000000, next_sec};
   // byte to the lower address first, in the family's byte order
   wire [7:0]  beat_byte = (next_sec ^ src_sty) ? src_w[7:0]
                                                 : src_w[15:8];
   wire [15:0] beat_dat = src_8 ? {8'h00, beat_byte} : src_w;
   wire [3:0]  ctl_a = src_8 ? {2'b00, beat_adr[0], ~beat_adr[0]}
                             : 4'h0;
   wire [3:0]  ctl_b = {2'b10, src_8, 1'b1};
   wire [3:0]  beat_ctl = (src_sty == STYLE_A) ? ctl_a : ctl_b;

   always_comb
   begin
      next_st = st;
      unique case (st)
         BM_IDLE: if (bm.req) next_st = BM_BEAT;
         BM_BEAT:
         begin
            if (abort) next_st = BM_IDLE;
            else if (bus_ack) next_st = last ? BM_IDLE : BM_GAP;
         end
         BM_GAP: next_st = abort ? BM_IDLE : BM_BEAT;
      endcase
   end

   assign bm.busy = (st != BM_IDLE);

   always_ff @(posedge clk)
   begin
      if (srst)
      begin
         st <= BM_IDLE;
         sec <= 1'b0;
         bus8_q <= 1'b0;
         style_q <= 1'b0;
         adr_q <= 24'h000000;
         w_q <= 16'h0000;
         bm.done <= 1'b0;
         bm.fault <= 1'b0;
      end
      else
      begin
         st <= next_st;
         sec <= next_sec;
         bus8_q <= src_8;
         style_q <= src_sty;
         adr_q <= src_adr;
         w_q <= src_w;
         bm.done <= ack_last;
         bm.fault <= (st != BM_IDLE) && abort; // see R13
      end
   end

   // pins follow the next state so they leave a flip-flop
   always_ff @(posedge clk)
   begin
      if (srst)
      begin
         bus_own <= 1'b0;
         bus_doe <= 1'b0;
         bus_addr <= 24'h000000;
         bus_dout <= 16'h0000;
         bus_ctl <= CTL_IDLE;
      end
      else
      begin
         bus_own <= (next_st != BM_IDLE);
         bus_doe <= (next_st == BM_BEAT);
         bus_addr <= beat_adr; // see R1
         bus_dout <= beat_dat; // see R2
         bus_ctl <= (next_st == BM_BEAT) ? beat_ctl : CTL_IDLE; // see R3
      end
   end

   a_even_wide: assert property (@(posedge clk) disable iff (srst) // see R5
      (bus_doe && !bus8_q) |-> !bus_addr[0])
      else $error("odd address on wide bus");
endmodule
`default_nettype wire

// File: core/hcs_ctrl.sv
// host command interpreter, operating state and event reporting
// assumes the host writes commands as one-cycle strobes on CLK
// How it works
// R1: drive 24-bit master address
// R2: 16-bit data bus, 8-bit option
// R3: bus signalling style caught after reset
// R4: byte order follows chosen style
// R5: halfwords sit on even addresses
// R6: always exactly one of three states
// R7: off-line runs commands only
// R8: on-line runs commands and frames
// R9: error state takes only idle, reset
// R10: reset lands in off-line
// R11: init or go-active goes on-line
// R12: go-idle returns to off-line
// R13: bus fault in own cycle is error
// R14: select or ack in own cycle is error
// R15: host stores arguments then writes code
// R16: commands decode into five groups
// R17: handshake FE on write, FF when done
// R18: host reads handshake before next command
// R19: queue entry per event, maskable source
// R20: interrupt only when host enables it
// R21: vector defaults 0F, normal or severe
// R22: host keeps circular queue slots free
// R23: host loads config address before init
// R24: init completes into on-line monitoring
// R25: error state starts no master cycles
`default_nettype none
module hcs_ctrl
   import hcs_pkg::*;
(
   input  wire logic          CLK,
   input  wire logic          SRST,
   input  wire logic          STYLE_SEL,
   input  wire logic          CMD_WR,
   input  wire logic [7:0]    CMD_CODE,
   output logic [7:0]         CMD_HS,
   output logic [4:0]         CMD_GROUP,
   output logic               CMD_REFUSED,
   input  wire logic          DATA_WR,
   input  wire logic [31:0]   DATA_IN,
   output logic [23:0]        GCB_ADDR,
   input  wire logic          VEC_WR,
   input  wire logic [7:0]    VEC_IN,
   input  wire logic          IRQ_EN,
   input  wire logic [23:0]   IQ_BASE,
   input  wire logic [7:0]    IQ_LEN,
   input  wire logic [15:0]   SRC_MASK,
   input  wire logic          EVT_VALID,
   input  wire logic [3:0]    EVT_SRC,
   input  wire logic [7:0]    EVT_CAUSE,
   input  wire logic [12:0]   EVT_LINK,
   input  wire logic          EVT_HAS_LINK,
   input  wire logic          EVT_SEVERE,
   output logic               EVT_READY,
   output logic               IRQ,
   output logic [7:0]         VEC_OUT,
   output logic               VEC_OE,
   output logic [2:0]         OP_STATE,
   output logic               FRAMES_EN,
   output logic               BUS_WIDE,
   output logic               STYLE,
   input  wire logic          BUS_ACK,
   input  wire logic          BUS_FAULT,
   input  wire logic          DEV_SEL,
   input  wire logic          INT_ACK,
   output logic [23:0]        BUS_ADDR,
   output logic [15:0]        BUS_DOUT,
   output logic               BUS_DOE,
   output logic [3:0]         BUS_CTL,
   output logic               BUS_OWN
);
   // ----------------------------------------------------
   // command decode
   // ----------------------------------------------------
   function automatic logic [4:0] cmd_group(input logic [7:0] c);
      logic [2:0] g;
      g = c[7:GRP_LSB];
      cmd_group = (int'(g) < NUM_GRP) ? 5'(5'h01 << g) : 5'h00;
   endfunction

   hcs_op_t     op;
   hcs_op_t     next_op;
   hcs_eq_t     eq;
   hcs_eq_t     next_eq;
   logic        cmd_pend;
   logic [7:0]  cmd_q;
   logic [7:0]  vec;
   logic        bus8;
   logic        style_done;
   logic [7:0]  idx;
   logic        sev_pend;
   logic [15:0] ent0;
   logic [15:0] ent1;

   hcs_bm_if bm ();

   wire [4:0] grp = cmd_group(cmd_q); // see R16
   wire is_reset = (cmd_q == CMD_RESET);
   wire is_idle = (cmd_q == CMD_GO_IDLE);
   wire is_init = (cmd_q == CMD_INIT);
   wire is_act = (cmd_q == CMD_GO_ACTIVE);
   wire go_line = is_init || is_act;
   // error state takes only the two commands that leave it
   wire allowed = (op == ST_ERR) ? (is_idle || is_reset) // see R9
                                 : (grp != 5'h00);
   wire exec = cmd_pend && allowed;
   wire refuse = cmd_pend && !allowed;
   wire do_reset = exec && is_reset;
   wire quit = exec && (is_idle || is_reset);

   // ----------------------------------------------------
   // operating state
   // ----------------------------------------------------
   always_comb
   begin
      next_op = op;
      unique case (op)
         ST_OFF:
         begin
            if (bm.fault && !quit) next_op = ST_ERR; // see R13
            else if (exec && go_line) next_op = ST_ON; // see R11
         end
         ST_ON:
         begin
            if (quit) next_op = ST_OFF; // see R12
            else if (bm.fault) next_op = ST_ERR; // see R14
         end
         ST_ERR:
         begin
            if (exec) next_op = ST_OFF; // see R12
         end
         default: next_op = ST_OFF;
      endcase
   end

   always_ff @(posedge CLK)
   begin
      if (SRST)
      begin
         op <= ST_OFF; // see R10
         OP_STATE <= ST_OFF;
         FRAMES_EN <= 1'b0;
      end
      else
      begin
         op <= next_op; // see R6
         OP_STATE <= next_op;
         // frames only move while on-line
         FRAMES_EN <= (next_op == ST_ON); // see R7, R8, R24
      end
   end

   // ----------------------------------------------------
   // command register and handshake
   // ----------------------------------------------------
   always_ff @(posedge CLK)
   begin
      if (SRST)
      begin
         cmd_pend <= 1'b0;
         cmd_q <= 8'h00;
         CMD_HS <= HS_DONE;
         CMD_GROUP <= 5'h00;
         CMD_REFUSED <= 1'b0;
      end
      else
      begin
         cmd_pend <= CMD_WR;
         if (CMD_WR)
            cmd_q <= CMD_CODE;
         // a new write wins over the finish of the last one
         if (CMD_WR)
            CMD_HS <= HS_BUSY; // see R17
         else if (cmd_pend)
            CMD_HS <= HS_DONE; // see R17
         if (cmd_pend)
            CMD_GROUP <= grp;
         CMD_REFUSED <= refuse;
      end
   end

   // ----------------------------------------------------
   // configuration: data register, vector, width, style
   // ----------------------------------------------------
   always_ff @(posedge CLK)
   begin
      if (SRST || do_reset)
      begin
         vec <= VEC_RESET; // see R21
         bus8 <= 1'b0;
      end
      else
      begin
         if (VEC_WR)
            vec <= VEC_IN;
         if (exec && (cmd_q == CMD_BUS8))
            bus8 <= 1'b1; // see R2
         else if (exec && (cmd_q == CMD_BUS16))
            bus8 <= 1'b0;
      end
   end

   always_ff @(posedge CLK)
   begin
      if (SRST)
         GCB_ADDR <= 24'h000000;
      else if (DATA_WR)
         GCB_ADDR <= DATA_IN[23:0]; // see R23
   end

   // strap is sampled once, on the first edge after release
   always_ff @(posedge CLK)
   begin
      if (SRST)
      begin
         style_done <= 1'b0;
         STYLE <= STYLE_A;
      end
      else if (!style_done)
      begin
         style_done <= 1'b1;
         STYLE <= STYLE_SEL; // see R3
      end
   end

   always_ff @(posedge CLK)
   begin
      if (SRST)
         BUS_WIDE <= 1'b1;
      else
         BUS_WIDE <= !bus8;
   end

   // ----------------------------------------------------
   // interrupt queue writer
   // ----------------------------------------------------
   wire take = EVT_VALID && EVT_READY;
   wire masked = SRC_MASK[EVT_SRC];
   wire [7:0] idx_inc = idx + 8'h01;
   // a length of zero behaves as a single slot
   wire [7:0] idx_nxt = (idx_inc >= IQ_LEN) ? 8'h00 : idx_inc;
   wire [23:0] slot = IQ_BASE + (24'(idx) << SLOT_SHIFT);
   wire w1_done = (eq == EQ_W1) && bm.done;

   always_comb
   begin
      next_eq = eq;
      unique case (eq)
         EQ_IDLE: if (take && !masked) next_eq = EQ_W0; // see R19
         EQ_W0:
         begin
            if (bm.fault) next_eq = EQ_IDLE;
            else if (bm.done) next_eq = EQ_W1;
         end
         EQ_W1: if (bm.fault || bm.done) next_eq = EQ_IDLE;
         default: next_eq = EQ_IDLE;
      endcase
      if (do_reset) next_eq = EQ_IDLE;
   end

   // no new master cycle once a fault is reported or in the error state
   assign bm.req = (eq != EQ_IDLE) && !bm.busy && !bm.done && !bm.fault
                   && (op != ST_ERR) && !do_reset; // see R25
   assign bm.addr = (eq == EQ_W1) ? (slot + HALF_OFS) : slot; // see R5
   assign bm.wdata = (eq == EQ_W1) ? ent1 : ent0;
   assign bm.bus8 = bus8;
   assign bm.style = STYLE; // see R4

   always_ff @(posedge CLK)
   begin
      if (SRST)
      begin
         eq <= EQ_IDLE;
         ent0 <= 16'h0000;
         ent1 <= 16'h0000;
         idx <= 8'h00;
         EVT_READY <= 1'b0;
      end
      else
      begin
         eq <= next_eq;
         if (take)
         begin
            ent0 <= {EVT_HAS_LINK, 2'b00, EVT_LINK};
            ent1 <= {EVT_SEVERE, 7'h00, EVT_CAUSE};
         end
         if (do_reset)
            idx <= 8'h00;
         else if (w1_done)
            idx <= idx_nxt;
         EVT_READY <= (next_eq == EQ_IDLE) && (next_op != ST_ERR)
                      && !(take && !masked);
      end
   end

   // ----------------------------------------------------
   // interrupt request and vector
   // ----------------------------------------------------
   wire ack_take = INT_ACK && !bm.busy;

   always_ff @(posedge CLK)
   begin
      if (SRST || do_reset)
      begin
         IRQ <= 1'b0;
         sev_pend <= 1'b0;
         VEC_OUT <= 8'h00;
         VEC_OE <= 1'b0;
      end
      else
      begin
         // a new entry wins over an acknowledge in the same cycle
         if (w1_done && IRQ_EN)
            IRQ <= 1'b1; // see R20
         else if (ack_take)
            IRQ <= 1'b0;
         if (w1_done && IRQ_EN)
            sev_pend <= sev_pend || ent1[15];
         else if (ack_take)
            sev_pend <= 1'b0;
         VEC_OE <= ack_take;
         VEC_OUT <= sev_pend ? (vec + SEV_STEP) : vec; // see R21
      end
   end

   hcs_bus_master u_bm (
      .clk       (CLK),
      .srst      (SRST),
      .bm        (bm),
      .bus_ack   (BUS_ACK),
      .bus_fault (BUS_FAULT),
      .dev_sel   (DEV_SEL),
      .int_ack   (INT_ACK),
      .bus_addr  (BUS_ADDR),
      .bus_dout  (BUS_DOUT),
      .bus_doe   (BUS_DOE),
      .bus_ctl   (BUS_CTL),
      .bus_own   (BUS_OWN)
   );

   // ----------------------------------------------------
   // checks
   // ----------------------------------------------------
   default clocking cb @(posedge CLK); endclocking
   default disable iff (SRST);

   sequence s_cmd_alone;
      CMD_WR ##1 !CMD_WR;
   endsequence

   sequence s_err_cmd;
      (op == ST_ERR) && cmd_pend && !is_idle && !is_reset;
   endsequence

   a_state_onehot: assert property ($onehot(op)) // see R6
      else $error("operating state not one-hot");
   a_hs_busy: assert property (CMD_WR |=> CMD_HS == HS_BUSY) // see R17
      else $error("handshake not busy after write");
   a_hs_done: assert property (s_cmd_alone |=> CMD_HS == HS_DONE) // see R17
      else $error("handshake not done after command");
   a_err_refuse: assert property (s_err_cmd |=> // see R9
      (op == ST_ERR) && CMD_REFUSED)
      else $error("command taken in error state");
   a_fault_error: assert property ((bm.fault && !(exec && // see R13
      (is_idle || is_reset))) |=> op == ST_ERR)
      else $error("fault did not reach error state");
   a_err_quiet: assert property ((op == ST_ERR) |-> // see R25
      ##1 !BUS_OWN [*2])
      else $error("master cycle in error state");
   a_init_online: assert property ((exec && is_init && // see R11
      !bm.fault) |=> (op == ST_ON) && FRAMES_EN)
      else $error("init did not bring on-line");
   a_idle_off: assert property ((exec && is_idle) |=> // see R12
      op == ST_OFF)
      else $error("go-idle did not bring off-line");
   a_irq_gate: assert property ($rose(IRQ) |-> $past(IRQ_EN)) // see R20
      else $error("interrupt raised while disabled");
   a_mask_drop: assert property ((take && masked && eq == EQ_IDLE) // see R19
      |=> eq == EQ_IDLE)
      else $error("masked event written to queue");
   a_vec_reset: assert property ($fell(SRST) |-> // see R21
      vec == VEC_RESET)
      else $error("vector not at default after reset");
endmodule
`default_nettype wire

// File: sim/hcs_mem_model.sv
// shared memory on the system bus, seen from the controller as slave
// assumes one write beat per request; ack after lat wait cycles
`default_nettype none
module hcs_mem_model
(
   input  wire logic        clk,
   input  wire logic        srst,
   input  wire logic        own,
   input  wire logic        doe,
   input  wire logic [3:0]  ctl,
   input  wire logic [23:0] addr,
   input  wire logic [15:0] dout,
   input  wire integer      lat,
   output logic             ack
);
   timeunit 1ns;
   timeprecision 1ps;
   // ------------------------------------------
   // byte lanes decoded from the control strobes
   // ------------------------------------------
   logic [7:0] mem [256];
   int         cnt;
   wire logic  act = own && ctl != 4'hF;
   // family A: both data strobes low; family B: byte-high enable low
   wire logic  wide = ctl[3] ? !ctl[1] : ctl[1:0] == 2'b00;
   initial
      ack = 1'b0;
   always @(posedge clk)
   begin
      if (srst || !act)
      begin
         ack <= 1'b0;
         cnt <= 0;
      end
      else if (ack)
      begin
         ack <= 1'b0;
         // a halfword covers an even byte pair; order by family
         if (doe && wide)
         begin
            mem[{addr[7:1], ctl[3]}]  <= dout[15:8];
            mem[{addr[7:1], !ctl[3]}] <= dout[7:0];
         end
         else if (doe)
            mem[addr[7:0]] <= dout[7:0];
      end
      else if (cnt >= lat)
         ack <= 1'b1;
      else
         cnt <= cnt + 1;
      // stale bytes must not look like a fresh entry
      if (srst)
         foreach (mem[i])
            mem[i] <= 8'hEE;
   end
endmodule
`default_nettype wire

// File: sim/host_command_state_ctrl_test.sv
// self-checking bench of hcs_ctrl: command table, queue, faults
// assumes hcs_mem_model acknowledges every master write
`default_nettype none
module host_command_state_ctrl_test import hcs_pkg::*;;
   timeunit 1ns;
   timeprecision 1ps;
   logic        CLK = 0, SRST = 1, STYLE_SEL = 0, CMD_WR = 0, sty = 0;
   logic        DATA_WR = 0, VEC_WR = 0, IRQ_EN = 0, EVT_VALID = 0;
   logic        EVT_HAS_LINK = 0, EVT_SEVERE = 0;
   logic [7:0]  CMD_CODE = 8'h00, VEC_IN = 8'h00, EVT_CAUSE = 8'h00;
   logic [7:0]  IQ_LEN = 8'h02;
   logic [31:0] DATA_IN = 32'h0;
   logic [23:0] IQ_BASE = 24'h000040;
   logic [15:0] SRC_MASK = 16'h0000;
   logic [3:0]  EVT_SRC = 4'h0;
   logic [12:0] EVT_LINK = 13'h0;
   logic [2:0]  flt = 3'h0;
   int          lat = 0, cycles = 0, bad_count = 0, num_checks = 0;
   logic [7:0]  CMD_HS, VEC_OUT;
   logic [4:0]  CMD_GROUP;
   logic [23:0] GCB_ADDR, BUS_ADDR;
   logic [15:0] BUS_DOUT;
   logic [3:0]  BUS_CTL;
   logic [2:0]  OP_STATE;
   logic        CMD_REFUSED, EVT_READY, IRQ, VEC_OE, FRAMES_EN;
   logic        BUS_WIDE, STYLE, BUS_ACK, BUS_DOE, BUS_OWN;
   // row: code, state after, one-hot group, refused
   localparam logic [16:0] ROWS [11] = '{
      {8'h01, 3'b010, 5'h01, 1'b0}, {8'h40, 3'b001, 5'h04, 1'b0},
      {8'h41, 3'b010, 5'h04, 1'b0}, {8'h20, 3'b010, 5'h02, 1'b0},
      {8'h60, 3'b010, 5'h08, 1'b0}, {8'h80, 3'b010, 5'h10, 1'b0},
      {8'hA0, 3'b010, 5'h00, 1'b1}, {8'hE0, 3'b010, 5'h00, 1'b1},
      {8'h03, 3'b010, 5'h01, 1'b0}, {8'h02, 3'b010, 5'h01, 1'b0},
      {8'h00, 3'b001, 5'h01, 1'b0}};
   hcs_ctrl u_hcs_ctrl
   (
      .CLK, .SRST, .STYLE_SEL, .CMD_WR, .CMD_CODE, .CMD_HS, .CMD_GROUP,
      .CMD_REFUSED, .DATA_WR, .DATA_IN, .GCB_ADDR, .VEC_WR, .VEC_IN,
      .IRQ_EN, .IQ_BASE, .IQ_LEN, .SRC_MASK, .EVT_VALID, .EVT_SRC,
      .EVT_CAUSE, .EVT_LINK, .EVT_HAS_LINK, .EVT_SEVERE, .EVT_READY,
      .IRQ, .VEC_OUT, .VEC_OE, .OP_STATE, .FRAMES_EN, .BUS_WIDE, .STYLE,
      .BUS_ACK, .BUS_FAULT (flt[0]), .DEV_SEL (flt[1]),
      .INT_ACK (flt[2]), .BUS_ADDR, .BUS_DOUT, .BUS_DOE, .BUS_CTL,
      .BUS_OWN
   );
   hcs_mem_model u_hcs_mem_model
   (
      .clk (CLK), .srst (SRST), .own (BUS_OWN), .doe (BUS_DOE),
      .ctl (BUS_CTL), .addr (BUS_ADDR), .dout (BUS_DOUT), .lat (lat),
      .ack (BUS_ACK)
   );
   always #5 CLK = ~CLK;
   // ------------------------------------------
   // helpers
   // ------------------------------------------
   task automatic conclude();
      $display("checks %0d mismatches %0d", num_checks, bad_count);
      if (bad_count == 0 && num_checks > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask
   // a hang ends the run as a failure
   always @(posedge CLK)
   begin
      cycles <= cycles + 1;
      if (cycles == 4000)
      begin
         bad_count++;
         conclude();
      end
   end
   task automatic chk(string n, logic [23:0] e, logic [23:0] g);
      num_checks++;
      if (g !== e)
      begin
         bad_count++;
         $display("mismatch %s expected %h seen %h", n, e, g);
      end
   endtask
   task automatic done(string n);
      $display("test %s done", n);
   endtask
   task automatic tick(int n);
      repeat (n) @(posedge CLK);
   endtask
   function automatic logic [15:0] rd16(logic [7:0] a);
      return sty ? {u_hcs_mem_model.mem[a + 1], u_hcs_mem_model.mem[a]}
                 : {u_hcs_mem_model.mem[a], u_hcs_mem_model.mem[a + 1]};
   endfunction
   task automatic do_reset(logic s);
      @(posedge CLK);
      SRST <= 1'b1;
      STYLE_SEL <= s;
      sty = s;
      tick(3);
      SRST <= 1'b0;
      tick(1);
      // the strap moves after capture and must be ignored
      STYLE_SEL <= ~s;
      tick(1);
      #1 chk("style", s, STYLE);
      chk("hs reset", HS_DONE, CMD_HS);
      chk("state reset", ST_OFF, OP_STATE);
      chk("wide reset", 1'b1, BUS_WIDE);
      chk("reset outs", 5'h10,
          {EVT_READY, IRQ, VEC_OE, FRAMES_EN, BUS_OWN});
      chk("gcb reset", 24'h0, GCB_ADDR);
   endtask
   task automatic cmd(logic [7:0] c, logic [2:0] st, logic r);
      @(posedge CLK);
      CMD_WR <= 1'b1;
      CMD_CODE <= c;
      @(posedge CLK);
      CMD_WR <= 1'b0;
      #1 chk("hs busy", HS_BUSY, CMD_HS);
      @(posedge CLK);
      #1 chk("hs done", HS_DONE, CMD_HS);
      chk("refused", r, CMD_REFUSED);
      chk("state", st, OP_STATE);
      chk("frames", st == ST_ON, FRAMES_EN);
   endtask
   task automatic evt(logic [3:0] s, logic [7:0] c, logic [12:0] l,
                      logic h, logic v);
      @(posedge CLK);
      EVT_VALID <= 1'b1;
      {EVT_SRC, EVT_CAUSE, EVT_LINK, EVT_HAS_LINK, EVT_SEVERE}
         <= {s, c, l, h, v};
      @(posedge CLK);
      for (int i = 0; i < 40 && EVT_READY !== 1'b1; i++)
         @(posedge CLK);
      EVT_VALID <= 1'b0;
      @(posedge CLK);
      for (int i = 0; i < 40 && EVT_READY !== 1'b1; i++)
         @(posedge CLK);
      tick(2);
      #1;
   endtask
   task automatic entry(logic [7:0] a, logic [3:0] s, logic [7:0] c,
                        logic [12:0] l, logic h, logic v);
      evt(s, c, l, h, v);
      chk("entry link", {h, 2'b00, l}, rd16(a));
      chk("entry cause", {v, 7'h00, c}, rd16(a + 8'h02));
   endtask
   task automatic iack(logic [7:0] v);
      @(posedge CLK);
      flt <= 3'b100;
      @(posedge CLK);
      flt <= 3'b000;
      #1 chk("vec oe", 1'b1, VEC_OE);
      chk("vector", v, VEC_OUT);
      chk("irq clear", 1'b0, IRQ);
   endtask
   task automatic fault(int k, logic [7:0] ex);
      cmd(CMD_INIT, ST_ON, 1'b0);
      @(posedge CLK);
      lat <= 6;
      EVT_VALID <= 1'b1;
      for (int i = 0; i < 30 && BUS_OWN !== 1'b1; i++)
         @(posedge CLK);
      flt <= 3'(1 << k);
      EVT_VALID <= 1'b0;
      @(posedge CLK);
      flt <= 3'b000;
      tick(2);
      #1 chk("err state", ST_ERR, OP_STATE);
      chk("frames err", 1'b0, FRAMES_EN);
      chk("ready err", 1'b0, EVT_READY);
      @(posedge CLK);
      EVT_VALID <= 1'b1;
      repeat (8)
      begin
         @(posedge CLK);
         chk("no master", 1'b0, BUS_OWN);
      end
      EVT_VALID <= 1'b0;
      lat <= 0;
      cmd(CMD_INIT, ST_ERR, 1'b1);
      cmd(ex, ST_OFF, 1'b0);
   endtask
   // ------------------------------------------
   // main sequence
   // ------------------------------------------
   initial
   begin
      do_reset(1'b0);
      done("reset family A");
      @(posedge CLK);
      DATA_WR <= 1'b1;
      DATA_IN <= 32'hAB123456;
      @(posedge CLK);
      DATA_WR <= 1'b0;
      #1 chk("gcb", 24'h123456, GCB_ADDR);
      foreach (ROWS[i])
      begin
         cmd(ROWS[i][16:9], ROWS[i][8:6], ROWS[i][0]);
         chk("group", ROWS[i][5:1], CMD_GROUP);
      end
      done("command table");
      @(posedge CLK);
      CMD_WR <= 1'b1;
      CMD_CODE <= CMD_INIT;
      @(posedge CLK);
      CMD_CODE <= CMD_GO_IDLE;
      @(posedge CLK);
      CMD_WR <= 1'b0;
      #1 chk("hs b2b", HS_BUSY, CMD_HS);
      @(posedge CLK);
      #1 chk("state b2b", ST_OFF, OP_STATE);
      done("back to back");
      cmd(CMD_INIT, ST_ON, 1'b0);
      iack(VEC_RESET);
      @(posedge CLK);
      VEC_WR <= 1'b1;
      VEC_IN <= 8'h30;
      IRQ_EN <= 1'b1;
      @(posedge CLK);
      VEC_WR <= 1'b0;
      entry(8'h40, 4'h3, 8'h5A, 13'h1234, 1'b1, 1'b0);
      chk("irq set", 1'b1, IRQ);
      iack(8'h30);
      entry(8'h44, 4'h7, 8'hC3, 13'h0ABC, 1'b0, 1'b1);
      iack(8'h31);
      @(posedge CLK);
      IRQ_EN <= 1'b0;
      entry(8'h40, 4'h5, 8'h11, 13'h1FFF, 1'b1, 1'b0);
      chk("irq polled", 1'b0, IRQ);
      @(posedge CLK);
      IRQ_EN <= 1'b1;
      SRC_MASK <= 16'h0080;
      evt(4'h7, 8'h99, 13'h0555, 1'b1, 1'b0);
      chk("masked mem", 16'h0ABC, rd16(8'h44));
      chk("masked irq", 1'b0, IRQ);
      @(posedge CLK);
      SRC_MASK <= 16'h0000;
      done("interrupt queue");
      cmd(CMD_BUS8, ST_ON, 1'b0);
      // the width output follows the executed command one cycle later
      tick(1);
      #1 chk("wide", 1'b0, BUS_WIDE);
      entry(8'h44, 4'h2, 8'h6E, 13'h0F0F, 1'b1, 1'b1);
      iack(8'h31);
      done("byte bus");
      for (int k = 0; k < 3; k++)
         fault(k, k == 1 ? CMD_RESET : CMD_GO_IDLE);
      done("bus faults");
      do_reset(1'b1);
      cmd(CMD_INIT, ST_ON, 1'b0);
      entry(8'h40, 4'h1, 8'hA5, 13'h1357, 1'b1, 1'b0);
      cmd(CMD_BUS8, ST_ON, 1'b0);
      entry(8'h44, 4'h4, 8'h3C, 13'h0246, 1'b0, 1'b1);
      done("family B");
      conclude();
   end
endmodule
`default_nettype wire
